// [hw/cmcc_params.svh]
// Purpose: constants for the core module clock configuration block
// Assumes: one 20 MHz clock, asynchronous active-low reset
// Notes:   widths follow the divider pin groups of both synthesisers
//
// Notes on behaviour
// - All clock generation runs on the block's own clock, never on motherboard timing.
// - The core clock is settable in 1 MHz steps from 12 MHz to 160 MHz.
// - The core VCO and output divider pins follow their fields; the reference divider is fixed.
// - Core reference divider pins carry 22, VCO divider spans 4 to 152, output divider 2 to 10.
// - Core clock in MHz is two times the core VCO word plus 8, divided by the output divider.
// - The double-rate bus clock is divided by two to give the bus clock and its inverse.
// - The local bus clock is settable in 0.5 MHz steps from 6 MHz to 66 MHz.
// - The double-rate VCO and output divider pins follow the bus fields; reference is fixed.
// - Bus reference divider pins carry 22, VCO divider spans 4 to 124, output divider 2 to 10.
// - Local bus clock in MHz is the bus VCO word plus 8, divided by the bus output divider.
// - The inverted bus clock is the exact complement of the bus clock, edges aligned.
// - A fixed 24 MHz reference clock is passed on for refresh and presence-detect timing.
`ifndef CMCC_PARAMS_SVH
`define CMCC_PARAMS_SVH

`define CMCC_REF_DIV_W      7
`define CMCC_CORE_VCO_W     8
`define CMCC_BUS_VCO_W      7
`define CMCC_OD_W           4
`define CMCC_NUM_W          9
`define CMCC_CNT_W          4

`define CMCC_REF_DIV        7'h16
`define CMCC_VCO_OFFSET     9'h008
`define CMCC_CORE_VCO_MIN   8'h04
`define CMCC_CORE_VCO_MAX   8'h98
`define CMCC_BUS_VCO_MIN    7'h04
`define CMCC_BUS_VCO_MAX    7'h7c
`define CMCC_OD_MIN         4'h2
`define CMCC_OD_MAX         4'ha

`define CMCC_CORE_VCO_RST   8'h0c
`define CMCC_BUS_VCO_RST    7'h0c
`define CMCC_OD_RST         4'h2

// frequencies in MHz (core) and half-MHz units (bus)
`define CMCC_CORE_MHZ_MIN   9'h00c
`define CMCC_CORE_MHZ_MAX   9'h0a0
`define CMCC_BUS_HALF_MIN   9'h00c
`define CMCC_BUS_HALF_MAX   9'h084

`define CMCC_DIV_STEPS      4'h9

`endif

// [hw/cmcc_pkg.sv]
// Purpose: shared types for the clock configuration block
// Assumes: cmcc_params.svh supplies the widths
// Notes:   types only, no constants of value
`include "cmcc_params.svh"

package cmcc_pkg;
    typedef logic [`CMCC_CORE_VCO_W-1:0] cmcc_core_vco_t;
    typedef logic [`CMCC_BUS_VCO_W-1:0]  cmcc_bus_vco_t;
    typedef logic [`CMCC_OD_W-1:0]       cmcc_od_t;
    typedef logic [`CMCC_NUM_W-1:0]      cmcc_num_t;
    typedef enum logic {CMCC_IDLE, CMCC_RUN} cmcc_div_state_t;
endpackage

// [hw/cmcc_div_if.sv]
// Purpose: request and answer between the top and a frequency divider
// Assumes: single clock domain
// Notes:   start is a one-cycle pulse, done likewise
`timescale 1ns/100ps

interface cmcc_div_if;
    import cmcc_pkg::*;
    logic      start;
    cmcc_num_t numer;
    cmcc_od_t  denom;
    logic      done;
    cmcc_num_t quot;

    modport requester (output start, output numer, output denom,
                       input done, input quot);
    modport solver    (input start, input numer, input denom,
                       output done, output quot);
endinterface

// [hw/cmcc_freq_div.sv]
// Purpose: iterative restoring divide of numerator by output divider
// Assumes: denom is never zero (clamped by the caller)
// Notes:   nine cycles per answer; inputs captured at start
`timescale 1ns/100ps
`include "cmcc_params.svh"

module cmcc_freq_div
    import cmcc_pkg::*;
(
    input  wire logic     i_clk,
    input  wire logic     i_rst_n,
    cmcc_div_if.solver    div
);
    cmcc_div_state_t           state_r;
    cmcc_num_t                 num_r;
    cmcc_od_t                  den_r;
    logic [`CMCC_OD_W:0]       rem_r;
    cmcc_num_t                 quot_r;
    logic [`CMCC_CNT_W-1:0]    cnt_r;
    logic                      done_r;
    logic [`CMCC_OD_W:0]       rem_sh;
    logic                      fits;

    // shift in the next numerator bit, msb first
    always_comb begin
        rem_sh = {rem_r[`CMCC_OD_W-1:0], num_r[`CMCC_NUM_W-1]};
        fits   = (rem_sh >= {1'b0, den_r});
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= CMCC_IDLE;
            num_r   <= '0;
            den_r   <= '0;
            rem_r   <= '0;
            quot_r  <= '0;
            cnt_r   <= '0;
        end else begin
            case (state_r)
                CMCC_IDLE: begin
                    if (div.start) begin
                        num_r   <= div.numer;
                        den_r   <= div.denom;
                        rem_r   <= '0;
                        quot_r  <= '0;
                        cnt_r   <= `CMCC_DIV_STEPS;
                        state_r <= CMCC_RUN;
                    end
                end
                CMCC_RUN: begin
                    rem_r  <= fits ? (rem_sh - {1'b0, den_r}) : rem_sh;
                    quot_r <= {quot_r[`CMCC_NUM_W-2:0], fits};
                    num_r  <= {num_r[`CMCC_NUM_W-2:0], 1'b0};
                    cnt_r  <= cnt_r - 4'h1;
                    if (cnt_r == 4'h1) begin
                        state_r <= CMCC_IDLE;
                    end
                end
                default: begin
                    state_r <= CMCC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            done_r <= 1'b0;
        end else begin
            done_r <= (state_r == CMCC_RUN) && (cnt_r == 4'h1);
        end
    end

    assign div.done = done_r;
    assign div.quot = quot_r;
endmodule

// [hw/cmcc_top.sv]
// Purpose: divider pin drive, bus clock halving and frequency status
// Assumes: all inputs synchronous to i_clk, including sampled clocks
// Notes:   sampled clocks must be well below half of i_clk
`timescale 1ns/100ps
`include "cmcc_params.svh"

module cmcc_top
    import cmcc_pkg::*;
(
    input  wire logic                    i_clk,
    input  wire logic                    i_rst_n,
    input  wire logic                    i_osc_wr,
    input  wire logic [`CMCC_CORE_VCO_W-1:0] i_core_vco_word,
    input  wire logic [`CMCC_OD_W-1:0]   i_core_output_divider,
    input  wire logic [`CMCC_BUS_VCO_W-1:0]  i_bus_vco_word,
    input  wire logic [`CMCC_OD_W-1:0]   i_bus_output_divider,
    input  wire logic                    i_double_rate_bus_clock,
    input  wire logic                    i_fixed_reference_clock,
    output logic [`CMCC_REF_DIV_W-1:0]   o_core_ref_div_pins,
    output logic [`CMCC_CORE_VCO_W-1:0]  o_core_vco_pins,
    output logic [`CMCC_OD_W-1:0]        o_core_od_pins,
    output logic [`CMCC_REF_DIV_W-1:0]   o_bus_ref_div_pins,
    output logic [`CMCC_BUS_VCO_W-1:0]   o_bus_vco_pins,
    output logic [`CMCC_OD_W-1:0]        o_bus_od_pins,
    output logic                         o_local_bus_clock,
    output logic                         o_local_bus_clock_inverted,
    output logic                         o_fixed_reference_clock,
    output logic [`CMCC_NUM_W-1:0]       o_core_freq_mhz,
    output logic [`CMCC_NUM_W-1:0]       o_bus_freq_half_mhz,
    output logic                         o_core_in_range,
    output logic                         o_bus_in_range,
    output logic                         o_freq_valid
);
    cmcc_core_vco_t core_vco_r;
    cmcc_od_t       core_od_r;
    cmcc_bus_vco_t  bus_vco_r;
    cmcc_od_t       bus_od_r;
    logic           calc_req_r;
    logic           calc_busy_r;
    logic           core_done_r;
    logic           bus_done_r;
    logic           dr_prev_r;
    logic           lbc_r;
    logic           lbc_inv_r;
    logic           ref_r;
    logic [`CMCC_REF_DIV_W-1:0] core_ref_r;
    logic [`CMCC_REF_DIV_W-1:0] bus_ref_r;
    cmcc_num_t      core_sum;
    cmcc_num_t      bus_sum;
    cmcc_num_t      core_q_r;
    cmcc_num_t      bus_q_r;
    logic           core_ok_r;
    logic           bus_ok_r;
    logic           valid_r;
    cmcc_core_vco_t core_vco_nxt;
    cmcc_bus_vco_t  bus_vco_nxt;
    cmcc_od_t       core_od_nxt;
    cmcc_od_t       bus_od_nxt;

    cmcc_div_if core_div ();
    cmcc_div_if bus_div ();

    // clamp to the pin ranges so an out-of-range word cannot reach a pin
    always_comb begin
        core_vco_nxt = i_core_vco_word;
        if (i_core_vco_word < `CMCC_CORE_VCO_MIN)
            core_vco_nxt = `CMCC_CORE_VCO_MIN;
        else if (i_core_vco_word > `CMCC_CORE_VCO_MAX)
            core_vco_nxt = `CMCC_CORE_VCO_MAX;
        bus_vco_nxt = i_bus_vco_word;
        if (i_bus_vco_word < `CMCC_BUS_VCO_MIN)
            bus_vco_nxt = `CMCC_BUS_VCO_MIN;
        else if (i_bus_vco_word > `CMCC_BUS_VCO_MAX)
            bus_vco_nxt = `CMCC_BUS_VCO_MAX;
        core_od_nxt = i_core_output_divider;
        if (i_core_output_divider < `CMCC_OD_MIN)
            core_od_nxt = `CMCC_OD_MIN;
        else if (i_core_output_divider > `CMCC_OD_MAX)
            core_od_nxt = `CMCC_OD_MAX;
        bus_od_nxt = i_bus_output_divider;
        if (i_bus_output_divider < `CMCC_OD_MIN)
            bus_od_nxt = `CMCC_OD_MIN;
        else if (i_bus_output_divider > `CMCC_OD_MAX)
            bus_od_nxt = `CMCC_OD_MAX;
    end

    // fields only change on a write
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            core_vco_r <= `CMCC_CORE_VCO_RST;
            core_od_r  <= `CMCC_OD_RST;
            bus_vco_r  <= `CMCC_BUS_VCO_RST;
            bus_od_r   <= `CMCC_OD_RST;
        end else if (i_osc_wr) begin
            core_vco_r <= core_vco_nxt;
            core_od_r  <= core_od_nxt;
            bus_vco_r  <= bus_vco_nxt;
            bus_od_r   <= bus_od_nxt;
        end
    end

    // a write during a calculation is remembered and rerun afterwards
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            calc_req_r  <= 1'b1;
            calc_busy_r <= 1'b0;
        end else begin
            if (i_osc_wr)
                calc_req_r <= 1'b1;
            else if (calc_req_r && !calc_busy_r)
                calc_req_r <= 1'b0;
            if (calc_req_r && !calc_busy_r && !i_osc_wr)
                calc_busy_r <= 1'b1;
            else if (core_done_r && bus_done_r)
                calc_busy_r <= 1'b0;
        end
    end

    assign core_div.start = calc_req_r && !calc_busy_r && !i_osc_wr;
    assign bus_div.start  = calc_req_r && !calc_busy_r && !i_osc_wr;
    // both clocks use 2*(word+8): MHz for core, half-MHz for bus
    // sums stay below 256, so dropping the top bit before doubling is safe
    assign core_sum       = {1'b0, core_vco_r} + `CMCC_VCO_OFFSET;
    assign core_div.numer = {core_sum[7:0], 1'b0};
    assign core_div.denom = core_od_r;
    assign bus_sum        = {2'b00, bus_vco_r} + `CMCC_VCO_OFFSET;
    assign bus_div.numer  = {bus_sum[7:0], 1'b0};
    assign bus_div.denom  = bus_od_r;

    cmcc_freq_div u_core_div (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .div     (core_div.solver)
    );

    cmcc_freq_div u_bus_div (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .div     (bus_div.solver)
    );

    // both dividers take equal time, but capture each done separately
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            core_done_r <= 1'b0;
            bus_done_r  <= 1'b0;
            core_q_r    <= '0;
            bus_q_r     <= '0;
        end else begin
            if (core_div.start) begin
                core_done_r <= 1'b0;
                bus_done_r  <= 1'b0;
            end else begin
                if (core_div.done) begin
                    core_done_r <= 1'b1;
                    core_q_r    <= core_div.quot;
                end
                if (bus_div.done) begin
                    bus_done_r <= 1'b1;
                    bus_q_r    <= bus_div.quot;
                end
            end
        end
    end

    // range flags only; enforcing the module limit is software's job
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            core_ok_r <= 1'b0;
            bus_ok_r  <= 1'b0;
            valid_r   <= 1'b0;
        end else begin
            core_ok_r <= (core_q_r >= `CMCC_CORE_MHZ_MIN) &&
                         (core_q_r <= `CMCC_CORE_MHZ_MAX);
            bus_ok_r  <= (bus_q_r >= `CMCC_BUS_HALF_MIN) &&
                         (bus_q_r <= `CMCC_BUS_HALF_MAX);
            valid_r   <= !calc_req_r && !calc_busy_r && !i_osc_wr;
        end
    end

    // halve the double-rate clock; both phases toggle on the same edge
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dr_prev_r <= 1'b0;
            lbc_r     <= 1'b0;
            lbc_inv_r <= 1'b1;
        end else begin
            dr_prev_r <= i_double_rate_bus_clock;
            if (i_double_rate_bus_clock && !dr_prev_r) begin
                lbc_r     <= !lbc_r;
                lbc_inv_r <= lbc_r;
            end
        end
    end

    // own clock only, nothing taken from the motherboard
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ref_r <= 1'b0;
        end else begin
            ref_r <= i_fixed_reference_clock;
        end
    end

    // fixed pins kept in flops so every output leaves a register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            core_ref_r <= `CMCC_REF_DIV;
            bus_ref_r  <= `CMCC_REF_DIV;
        end else begin
            core_ref_r <= `CMCC_REF_DIV;
            bus_ref_r  <= `CMCC_REF_DIV;
        end
    end

    assign o_core_ref_div_pins        = core_ref_r;
    assign o_bus_ref_div_pins         = bus_ref_r;
    assign o_core_vco_pins            = core_vco_r;
    assign o_core_od_pins             = core_od_r;
    assign o_bus_vco_pins             = bus_vco_r;
    assign o_bus_od_pins              = bus_od_r;
    assign o_local_bus_clock          = lbc_r;
    assign o_local_bus_clock_inverted = lbc_inv_r;
    assign o_fixed_reference_clock    = ref_r;
    assign o_core_freq_mhz            = core_q_r;
    assign o_bus_freq_half_mhz        = bus_q_r;
    assign o_core_in_range            = core_ok_r;
    assign o_bus_in_range             = bus_ok_r;
    assign o_freq_valid               = valid_r;
endmodule

// [tb/cmcc_asserts.sv]
// Purpose: port checks for the clock configuration top
// Assumes: one i_clk domain, async active-low reset
// Notes:   bound to cmcc_top below the module
`timescale 1ns/100ps
`include "cmcc_params.svh"

module cmcc_asserts (
    input wire logic                         i_clk,
    input wire logic                         i_rst_n,
    input wire logic                         i_osc_wr,
    input wire logic [`CMCC_CORE_VCO_W-1:0]  i_core_vco_word,
    input wire logic [`CMCC_OD_W-1:0]        i_core_output_divider,
    input wire logic [`CMCC_BUS_VCO_W-1:0]   i_bus_vco_word,
    input wire logic [`CMCC_OD_W-1:0]        i_bus_output_divider,
    input wire logic                         i_double_rate_bus_clock,
    input wire logic                         i_fixed_reference_clock,
    input wire logic [`CMCC_REF_DIV_W-1:0]   o_core_ref_div_pins,
    input wire logic [`CMCC_CORE_VCO_W-1:0]  o_core_vco_pins,
    input wire logic [`CMCC_OD_W-1:0]        o_core_od_pins,
    input wire logic [`CMCC_REF_DIV_W-1:0]   o_bus_ref_div_pins,
    input wire logic [`CMCC_BUS_VCO_W-1:0]   o_bus_vco_pins,
    input wire logic [`CMCC_OD_W-1:0]        o_bus_od_pins,
    input wire logic                         o_local_bus_clock,
    input wire logic                         o_local_bus_clock_inverted,
    input wire logic                         o_fixed_reference_clock,
    input wire logic [`CMCC_NUM_W-1:0]       o_core_freq_mhz,
    input wire logic [`CMCC_NUM_W-1:0]       o_bus_freq_half_mhz,
    input wire logic                         o_core_in_range,
    input wire logic                         o_bus_in_range,
    input wire logic                         o_freq_valid
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // a write must drop valid, then a bounded rerun restores it
    sequence s_wr_taken;
        i_osc_wr ##1 !o_freq_valid;
    endsequence
    sequence s_rerun;
        ##[1:40] o_freq_valid;
    endsequence
    a_recalc_bound:
    assert property (i_osc_wr |-> s_wr_taken ##0 s_rerun)
        else $error("recalculation missing after write");
    a_ref_pins:
    assert property (o_core_ref_div_pins == `CMCC_REF_DIV
        && o_bus_ref_div_pins == `CMCC_REF_DIV)
        else $error("reference divider pins not fixed");
    a_inv_complement:
    assert property (o_local_bus_clock_inverted == !o_local_bus_clock)
        else $error("inverted bus clock not complement");
    a_lbc_halves:
    assert property ($rose(i_double_rate_bus_clock)
        |-> ##[1:2] $changed(o_local_bus_clock))
        else $error("bus clock missed a toggle");
    a_ref_delay:
    assert property ($past(i_rst_n)
        |-> o_fixed_reference_clock == $past(i_fixed_reference_clock))
        else $error("reference clock not passed on");
    a_pins_hold:
    assert property ($past(i_rst_n) && !$past(i_osc_wr)
        |-> $stable(o_core_vco_pins) && $stable(o_core_od_pins)
        && $stable(o_bus_vco_pins) && $stable(o_bus_od_pins))
        else $error("divider pins moved without write");
    a_core_follow:
    assert property (i_osc_wr && i_core_vco_word <= `CMCC_CORE_VCO_MAX
        && i_core_vco_word >= `CMCC_CORE_VCO_MIN
        |=> o_core_vco_pins == $past(i_core_vco_word))
        else $error("core vco pins do not follow word");
    a_core_freq:
    assert property (o_freq_valid |-> o_core_freq_mhz == (9'h002 *
        (o_core_vco_pins + `CMCC_VCO_OFFSET)) / o_core_od_pins)
        else $error("core frequency wrong");
    a_bus_freq:
    assert property (o_freq_valid |-> o_bus_freq_half_mhz == (9'h002 *
        (o_bus_vco_pins + `CMCC_VCO_OFFSET)) / o_bus_od_pins)
        else $error("bus frequency wrong");
    a_range_flags:
    assert property (o_freq_valid |-> o_core_in_range ==
        (o_core_freq_mhz inside {[`CMCC_CORE_MHZ_MIN:`CMCC_CORE_MHZ_MAX]})
        && o_bus_in_range == (o_bus_freq_half_mhz
        inside {[`CMCC_BUS_HALF_MIN:`CMCC_BUS_HALF_MAX]}))
        else $error("range flag wrong");
endmodule

bind cmcc_top cmcc_asserts u_chk (.*);

// [tb/tb_core_module_clock_config.sv]
// Purpose: self-checking bench for the clock configuration top
// Assumes: 20 MHz clock, inputs driven at the falling edge
// Notes:   model clamps fields as the design does
`timescale 1ns/100ps
`include "cmcc_params.svh"

module tb_core_module_clock_config;
    import cmcc_pkg::*;
    logic           i_clk, i_rst_n, i_osc_wr, lb, rf;
    logic           i_double_rate_bus_clock, i_fixed_reference_clock;
    cmcc_core_vco_t i_core_vco_word, o_core_vco_pins;
    cmcc_bus_vco_t  i_bus_vco_word, o_bus_vco_pins;
    cmcc_od_t       i_core_output_divider, i_bus_output_divider;
    cmcc_od_t       o_core_od_pins, o_bus_od_pins;
    logic [6:0]     o_core_ref_div_pins, o_bus_ref_div_pins;
    logic           o_local_bus_clock, o_local_bus_clock_inverted;
    logic           o_fixed_reference_clock, o_freq_valid;
    logic           o_core_in_range, o_bus_in_range;
    cmcc_num_t      o_core_freq_mhz, o_bus_freq_half_mhz;
    int             failures, n_compared, cycles;
    logic [31:0]    seed;
    int t[6][4] = '{'{4, 2, 4, 2}, '{152, 10, 124, 10}, '{0, 0, 0, 0},
        '{255, 15, 127, 15}, '{44, 10, 4, 2}, '{72, 1, 124, 2}};

    cmcc_top DUT (.*);

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic int clamp(input int v, input int lo, input int hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction
    task automatic close_out;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input cmcc_num_t got, input cmcc_num_t exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // strobe left high so two calls give back-to-back writes
    task automatic wr(input int cv, input int cd, input int bv, input int bd);
        i_osc_wr = 1'b1;
        i_core_vco_word = cv[7:0];
        i_core_output_divider = cd[3:0];
        i_bus_vco_word = bv[6:0];
        i_bus_output_divider = bd[3:0];
        @(negedge i_clk);
    endtask
    task automatic expect_all(input int cv, input int cd, input int bv,
                              input int bd);
        int k, cf, bf;
        i_osc_wr = 1'b0;
        cv = clamp(cv, 4, 152);
        cd = clamp(cd, 2, 10);
        bv = clamp(bv, 4, 124);
        bd = clamp(bd, 2, 10);
        cf = 2 * (cv + 8) / cd;
        bf = 2 * (bv + 8) / bd;
        chk(9'(o_freq_valid), 9'h000);
        k = 0;
        while (o_freq_valid !== 1'b1 && k < 60) begin
            @(negedge i_clk);
            k++;
        end
        chk(9'(o_freq_valid), 9'h001);
        chk(9'(o_core_vco_pins), 9'(cv));
        chk(9'(o_core_od_pins), 9'(cd));
        chk(9'(o_bus_vco_pins), 9'(bv));
        chk(9'(o_bus_od_pins), 9'(bd));
        chk(o_core_freq_mhz, 9'(cf));
        chk(o_bus_freq_half_mhz, 9'(bf));
        chk(9'(o_core_in_range), 9'(cf >= 12 && cf <= 160));
        chk(9'(o_bus_in_range), 9'(bf >= 12 && bf <= 132));
    endtask
    task automatic chk_rst;
        chk(9'(o_core_vco_pins), 9'h00c);
        chk(9'(o_bus_vco_pins), 9'h00c);
        chk(9'(o_core_od_pins), 9'h002);
        chk(9'(o_bus_od_pins), 9'h002);
        chk(9'(o_core_ref_div_pins), 9'h016);
        chk(9'(o_bus_ref_div_pins), 9'h016);
        chk(9'(o_local_bus_clock_inverted), 9'h001);
    endtask
    task automatic half(input logic v);
        i_double_rate_bus_clock = v;
        seed = xs(seed);
        rf = seed[3];
        i_fixed_reference_clock = rf;
        @(negedge i_clk);
        chk(9'(o_fixed_reference_clock), 9'(rf));
        repeat (2) @(negedge i_clk);
        chk(9'(o_local_bus_clock), 9'(lb));
        chk(9'(o_local_bus_clock_inverted), 9'(!lb));
    endtask

    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    // generous ceiling; the full run needs under two thousand cycles
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            close_out();
        end
    end

    initial begin
        {i_osc_wr, i_core_vco_word, i_core_output_divider} = '0;
        {i_bus_vco_word, i_bus_output_divider} = '0;
        {i_double_rate_bus_clock, i_fixed_reference_clock} = '0;
        i_rst_n = 1'b0;
        seed = 32'h0000004f;
        lb = 1'b0;
        repeat (8) @(negedge i_clk);
        chk_rst();
        i_rst_n = 1'b1;
        expect_all(12, 2, 12, 2);
        foreach (t[i]) begin
            wr(t[i][0], t[i][1], t[i][2], t[i][3]);
            expect_all(t[i][0], t[i][1], t[i][2], t[i][3]);
        end
        repeat (6) begin
            seed = xs(seed);
            wr(seed[7:0], seed[11:8], seed[18:12], seed[23:20]);
            expect_all(seed[7:0], seed[11:8], seed[18:12], seed[23:20]);
        end
        // back-to-back writes: the later one must win
        wr(152, 2, 4, 10);
        wr(30, 3, 100, 4);
        expect_all(30, 3, 100, 4);
        // second write lands mid-calculation and must be rerun afterwards
        wr(100, 5, 50, 3);
        i_osc_wr = 1'b0;
        repeat (4) @(negedge i_clk);
        wr(60, 4, 80, 6);
        expect_all(60, 4, 80, 6);
        repeat (6) begin
            lb = !lb;
            half(1'b1);
            half(1'b0);
        end
        i_rst_n = 1'b0;
        @(negedge i_clk);
        chk_rst();
        i_rst_n = 1'b1;
        expect_all(12, 2, 12, 2);
        close_out();
    end
endmodule
